// file: rtl/pirb_top.sv
`timescale 1ns/1ps
// Behaviour
// - Registers cover all sources except watchdog and both oscillator-fail traps.
// - A source request sets its flag to 1, held until cleared.
// - With interrupts enabled, a pending enabled flag raises a vectored request.
// - With interrupts disabled, flags still latch; software polls the request registers.
// - Timer and converter request register at FC0: bits 6, 5, 0; rest reserved.
// - Port A request register at FC3; bit 6 is pin 6 or comparator.
// - Port A bit x follows pin x for pins 0 to 5, bit 7 pin 7.
// - Port C request register at FC6; bits 3 to 0 pins; 7 to 4 reserved.
// - Enable pair decodes 00 off, 01 level 1, 10 level 2, 11 level 3.
// - Enable-high register at FC1: timer 1 bit 6, timer 0 bit 5, converter bit 0.
// - Enable-low register at FC2, same bits; bits 7, 2, 1 read-only.
// - CPU acknowledge clears the flag; software writing 0 clears it too.
// - Software writing 1 raises a request, cleared by acknowledge like hardware.
// - Level 3 before 2 before 1; within a level, fixed vector order.
// - Vectored requests only while master enable is set; acknowledge clears it.
module pirb_top (
    input  wire logic                    clk,
    input  wire logic                    nrst,
    input  wire pirb_pkg::pirb_reg_req_t reg_req,
    output logic [7:0]                   reg_rdata,
    input  wire pirb_pkg::pirb_src_t     src,
    input  wire logic [7:0]              port_a_enable_high,
    input  wire logic [7:0]              port_a_enable_low,
    input  wire logic [3:0]              port_c_enable_high,
    input  wire logic [3:0]              port_c_enable_low,
    input  wire logic                    master_enable_set,
    input  wire logic                    master_enable_clear,
    output logic                         master_interrupt_enable,
    output logic                         irq_request,
    output logic [3:0]                   irq_vector,
    input  wire logic                    irq_ack
);

    localparam int unsigned N = pirb_pkg::NUM_SOURCES;

    logic [7:0]   request_flags_timer_adc;
    logic [7:0]   request_flags_port_a;
    logic [7:0]   request_flags_port_c;
    logic [7:0]   enable_high_timer_adc;
    logic [7:0]   enable_low_timer_adc;
    logic [7:0]   set_timer_adc;
    logic [7:0]   set_port_c;
    logic [7:0]   clr_timer_adc;
    logic [7:0]   clr_port_a;
    logic [7:0]   clr_port_c;
    logic [N-1:0] ack_vec;
    logic [N-1:0] pending;
    logic [N-1:0] prio_high;
    logic [N-1:0] prio_low;
    logic         ack_take;
    logic         wr_timer_adc;
    logic         wr_port_a;
    logic         wr_port_c;
    logic         pick_found;
    logic [3:0]   pick_index;

    assign ack_take     = irq_ack && irq_request;
    assign ack_vec      = ack_take ? (15'h0001 << irq_vector) : 15'h0000;
    assign wr_timer_adc = reg_req.write && pirb_pkg::pirb_hit(reg_req.addr,
                                                               pirb_pkg::ADDR_REQ_TIMER_ADC);
    assign wr_port_a    = reg_req.write && pirb_pkg::pirb_hit(reg_req.addr,
                                                               pirb_pkg::ADDR_REQ_PORT_A);
    assign wr_port_c    = reg_req.write && pirb_pkg::pirb_hit(reg_req.addr,
                                                               pirb_pkg::ADDR_REQ_PORT_C);

    // Watchdog and oscillator-fail traps have no input here at all.
    assign set_timer_adc = {1'b0, src.timer_one, src.timer_zero, 4'h0, src.converter};
    assign clr_timer_adc = {1'b0, ack_vec[0], ack_vec[1], 4'h0, ack_vec[2]};
    assign set_port_c    = {4'h0, src.port_c};

    // Request flag registers; write, acknowledge and pulse merge inside.
    pirb_req_flags #(
        .WIDTH (8),
        .MASK  (pirb_pkg::MASK_TIMER_ADC)
    ) u_flags_timer_adc (
        .clk     (clk),
        .nrst    (nrst),
        .wr_en   (wr_timer_adc),
        .wdata   (reg_req.wdata),
        .hw_set  (set_timer_adc),
        .ack_clr (clr_timer_adc),
        .flags   (request_flags_timer_adc)
    );

    pirb_req_flags #(
        .WIDTH (8),
        .MASK  (pirb_pkg::MASK_PORT_A)
    ) u_flags_port_a (
        .clk     (clk),
        .nrst    (nrst),
        .wr_en   (wr_port_a),
        .wdata   (reg_req.wdata),
        .hw_set  (src.port_a),
        .ack_clr (clr_port_a),
        .flags   (request_flags_port_a)
    );

    pirb_req_flags #(
        .WIDTH (8),
        .MASK  (pirb_pkg::MASK_PORT_C)
    ) u_flags_port_c (
        .clk     (clk),
        .nrst    (nrst),
        .wr_en   (wr_port_c),
        .wdata   (reg_req.wdata),
        .hw_set  (set_port_c),
        .ack_clr (clr_port_c),
        .flags   (request_flags_port_c)
    );

    // Flatten sources into service order: timers, converter, port A 7..0, port C 3..0.
    assign pending[0]   = request_flags_timer_adc[pirb_pkg::BIT_TIMER_ONE];
    assign pending[1]   = request_flags_timer_adc[pirb_pkg::BIT_TIMER_ZERO];
    assign pending[2]   = request_flags_timer_adc[pirb_pkg::BIT_CONVERTER];
    assign prio_high[0] = enable_high_timer_adc[pirb_pkg::BIT_TIMER_ONE];
    assign prio_high[1] = enable_high_timer_adc[pirb_pkg::BIT_TIMER_ZERO];
    assign prio_high[2] = enable_high_timer_adc[pirb_pkg::BIT_CONVERTER];
    assign prio_low[0]  = enable_low_timer_adc[pirb_pkg::BIT_TIMER_ONE];
    assign prio_low[1]  = enable_low_timer_adc[pirb_pkg::BIT_TIMER_ZERO];
    assign prio_low[2]  = enable_low_timer_adc[pirb_pkg::BIT_CONVERTER];

    genvar k;
    generate
        for (k = 0; k < 8; k++)
        begin : g_port_a
            // Bit 6 carries pin 6 or the comparator, chosen outside this block.
            assign pending[pirb_pkg::SRC_PORT_A + k]   = request_flags_port_a[7 - k];
            assign prio_high[pirb_pkg::SRC_PORT_A + k] = port_a_enable_high[7 - k];
            assign prio_low[pirb_pkg::SRC_PORT_A + k]  = port_a_enable_low[7 - k];
            assign clr_port_a[7 - k]                   = ack_vec[pirb_pkg::SRC_PORT_A + k];
        end
        for (k = 0; k < 4; k++)
        begin : g_port_c
            assign pending[pirb_pkg::SRC_PORT_C + k]   = request_flags_port_c[3 - k];
            assign prio_high[pirb_pkg::SRC_PORT_C + k] = port_c_enable_high[3 - k];
            assign prio_low[pirb_pkg::SRC_PORT_C + k]  = port_c_enable_low[3 - k];
            assign clr_port_c[3 - k]                   = ack_vec[pirb_pkg::SRC_PORT_C + k];
        end
    endgenerate
    assign clr_port_c[7:4] = 4'h0;

    // Level decode and fixed-order pick.
    pirb_prio_pick #(
        .N (N),
        .W (pirb_pkg::SRC_W)
    ) u_pick (
        .pending (pending),
        .en_high (prio_high),
        .en_low  (prio_low),
        .found   (pick_found),
        .index   (pick_index)
    );

    always_ff @(posedge clk)
    begin
        if (!nrst)
            enable_high_timer_adc <= pirb_pkg::RESET_VALUE;
        else if (reg_req.write && pirb_pkg::pirb_hit(reg_req.addr, pirb_pkg::ADDR_EN_HIGH_TA))
            enable_high_timer_adc <= reg_req.wdata & pirb_pkg::MASK_TIMER_ADC;
    end

    // Bits 7, 2 and 1 are never written; 4 and 3 are plain storage.
    always_ff @(posedge clk)
    begin
        if (!nrst)
            enable_low_timer_adc <= pirb_pkg::RESET_VALUE;
        else if (reg_req.write && pirb_pkg::pirb_hit(reg_req.addr, pirb_pkg::ADDR_EN_LOW_TA))
            enable_low_timer_adc <= reg_req.wdata & pirb_pkg::MASK_EN_LOW_TA;
    end

    // Clear requests beat a set; acknowledge always drops the master enable.
    always_ff @(posedge clk)
    begin
        if (!nrst)
            master_interrupt_enable <= 1'b0;
        else if (ack_take || master_enable_clear)
            master_interrupt_enable <= 1'b0;
        else if (master_enable_set)
            master_interrupt_enable <= 1'b1;
    end

    // Vectored request; the taken source drops out at once.
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            irq_request <= 1'b0;
            irq_vector  <= 4'h0;
        end
        else
        begin
            irq_request <= master_interrupt_enable && pick_found && !ack_take;
            irq_vector  <= pick_index;
        end
    end

    // Read port; flags stay readable whatever the master enable holds.
    always_ff @(posedge clk)
    begin
        if (!nrst)
            reg_rdata <= 8'h00;
        else if (reg_req.read)
        begin
            case (reg_req.addr)
                pirb_pkg::ADDR_REQ_TIMER_ADC: reg_rdata <= request_flags_timer_adc;
                pirb_pkg::ADDR_EN_HIGH_TA:    reg_rdata <= enable_high_timer_adc;
                pirb_pkg::ADDR_EN_LOW_TA:     reg_rdata <= enable_low_timer_adc;
                pirb_pkg::ADDR_REQ_PORT_A:    reg_rdata <= request_flags_port_a;
                pirb_pkg::ADDR_REQ_PORT_C:    reg_rdata <= request_flags_port_c;
                default:                      reg_rdata <= 8'h00;
            endcase
        end
    end

    pirb_pkg::pirb_level_t sel_level;
    assign sel_level = pirb_pkg::pirb_decode_level(prio_high[irq_vector], prio_low[irq_vector]);

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    a_flag_set_pulse: assert property (
        src.timer_one |=> request_flags_timer_adc[6])
        else $error("Timer one pulse did not set its flag.");

    a_flag_holds_set: assert property (
        $fell(request_flags_port_a[3]) |->
            ($past(wr_port_a) && !$past(reg_req.wdata[3])) || $past(clr_port_a[3]))
        else $error("Port A flag 3 dropped without write or acknowledge.");

    a_polled_latch: assert property (
        !master_interrupt_enable && src.converter |=> request_flags_timer_adc[0])
        else $error("Converter flag not latched while interrupts disabled.");

    a_vector_forward: assert property (
        master_interrupt_enable && pick_found && !ack_take |=> irq_request)
        else $error("Enabled pending flag was not forwarded.");

    a_no_vector_off: assert property (
        !master_interrupt_enable |=> !irq_request)
        else $error("Request forwarded while master enable clear.");

    a_ack_master: assert property (
        ack_take |=> !master_interrupt_enable && !irq_request)
        else $error("Acknowledge did not clear master enable and request.");

    a_ack_clears: assert property (
        ack_take && irq_vector == pirb_pkg::SRC_TIMER_ONE && !src.timer_one && !wr_timer_adc
            |=> !request_flags_timer_adc[6])
        else $error("Acknowledge did not clear timer one flag.");

    a_sw_set_flag: assert property (
        wr_port_a && reg_req.wdata[2] |=> request_flags_port_a[2])
        else $error("Software write of one did not set port A flag 2.");

    a_set_wins: assert property (
        wr_timer_adc && !reg_req.wdata[5] && src.timer_zero |=> request_flags_timer_adc[5])
        else $error("Hardware pulse lost against a write of zero.");

    a_reserved_zero: assert property (
        (request_flags_timer_adc & ~pirb_pkg::MASK_TIMER_ADC) == 8'h00)
        else $error("Reserved timer and converter request bits not zero.");

    a_port_c_zero: assert property (
        request_flags_port_c[7:4] == 4'h0)
        else $error("Reserved port C request bits not zero.");

    a_enlow_readonly: assert property (
        (enable_low_timer_adc & 8'h86) == 8'h00)
        else $error("Read-only enable-low bits changed.");

    a_level_nonzero: assert property (
        irq_request |->
            ((($past(prio_high) | $past(prio_low)) >> irq_vector) & 15'h0001) != 15'h0000)
        else $error("Vector points at a disabled source.");

    a_level_order: assert property (
        master_interrupt_enable && !ack_take && pending[0] && pending[2] &&
        !(pending[1] && prio_high[1] && prio_low[1]) &&
        prio_low[0] && !prio_high[0] && prio_high[2] && prio_low[2]
            |=> irq_vector == pirb_pkg::SRC_CONVERTER)
        else $error("Level 3 converter not chosen over level 1 timer.");

    a_enhigh_readback: assert property (
        reg_req.read && reg_req.addr == pirb_pkg::ADDR_EN_HIGH_TA
            |=> reg_rdata == $past(enable_high_timer_adc))
        else $error("Enable-high read back wrong.");

    a_sw_clear_flag: assert property (
        wr_port_c && !reg_req.wdata[0] && !src.port_c[0] |=> !request_flags_port_c[0])
        else $error("Software write of zero did not clear port C flag 0.");

    a_master_set: assert property (
        master_enable_set && !master_enable_clear && !ack_take |=> master_interrupt_enable)
        else $error("Set pulse did not raise the master enable.");

    c_vectored_ack: cover property (irq_request ##1 ack_take);
    c_level_three: cover property (irq_request && sel_level == pirb_pkg::PIRB_LEVEL_HIGH);
    c_polled_read: cover property (!master_interrupt_enable && reg_req.read && pending != '0);
    c_set_wins: cover property (wr_port_a && !reg_req.wdata[0] && src.port_a[0]);

endmodule

// file: rtl/pirb_pkg.sv
package pirb_pkg;

    localparam int unsigned ADDR_W      = 12;
    localparam int unsigned DATA_W      = 8;
    localparam int unsigned NUM_SOURCES = 15;
    localparam int unsigned SRC_W       = 4;

    // Register addresses on the register file port.
    localparam logic [11:0] ADDR_REQ_TIMER_ADC = 12'hFC0;
    localparam logic [11:0] ADDR_EN_HIGH_TA    = 12'hFC1;
    localparam logic [11:0] ADDR_EN_LOW_TA     = 12'hFC2;
    localparam logic [11:0] ADDR_REQ_PORT_A    = 12'hFC3;
    localparam logic [11:0] ADDR_REQ_PORT_C    = 12'hFC6;

    // Field positions in the timer and converter registers.
    localparam int unsigned BIT_TIMER_ONE  = 6;
    localparam int unsigned BIT_TIMER_ZERO = 5;
    localparam int unsigned BIT_CONVERTER  = 0;

    // Bits that hold state; all others read as zero.
    localparam logic [7:0] MASK_TIMER_ADC = 8'h61;
    localparam logic [7:0] MASK_EN_LOW_TA = 8'h79;
    localparam logic [7:0] MASK_PORT_A    = 8'hFF;
    localparam logic [7:0] MASK_PORT_C    = 8'h0F;
    localparam logic [7:0] RESET_VALUE    = 8'h00;

    // Source positions in service order, zero being served first within a level.
    localparam logic [3:0] SRC_TIMER_ONE  = 4'h0;
    localparam logic [3:0] SRC_TIMER_ZERO = 4'h1;
    localparam logic [3:0] SRC_CONVERTER  = 4'h2;
    localparam int unsigned SRC_PORT_A    = 3;
    localparam int unsigned SRC_PORT_C    = 11;

    typedef enum logic [1:0] {
        PIRB_LEVEL_OFF,
        PIRB_LEVEL_LOW,
        PIRB_LEVEL_NOMINAL,
        PIRB_LEVEL_HIGH
    } pirb_level_t;

    typedef struct packed {
        logic       timer_one;
        logic       timer_zero;
        logic       converter;
        logic [7:0] port_a;
        logic [3:0] port_c;
    } pirb_src_t;

    typedef struct packed {
        logic        write;
        logic        read;
        logic [11:0] addr;
        logic [7:0]  wdata;
    } pirb_reg_req_t;

    function automatic pirb_level_t pirb_decode_level(input logic hi, input logic lo);
        return pirb_level_t'({hi, lo});
    endfunction

    function automatic logic pirb_hit(input logic [11:0] addr, input logic [11:0] target);
        return addr == target;
    endfunction

endpackage

// file: rtl/pirb_req_flags.sv
`timescale 1ns/1ps
module pirb_req_flags #(
    parameter int unsigned WIDTH = 8,
    parameter logic [7:0]  MASK  = 8'hFF
) (
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire logic             wr_en,
    input  wire logic [WIDTH-1:0] wdata,
    input  wire logic [WIDTH-1:0] hw_set,
    input  wire logic [WIDTH-1:0] ack_clr,
    output logic      [WIDTH-1:0] flags
);

    logic [WIDTH-1:0] next_flags;

    // A hardware pulse is ORed in after the write and acknowledge clear, so it survives a write of zero or an acknowledge.
    always_comb
    begin
        next_flags = wr_en ? wdata : flags;
        next_flags = (next_flags & ~ack_clr) | hw_set;
        next_flags = next_flags & MASK[WIDTH-1:0];
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
            flags <= pirb_pkg::RESET_VALUE[WIDTH-1:0];
        else
            flags <= next_flags;
    end

endmodule

// file: rtl/pirb_prio_pick.sv
`timescale 1ns/1ps
module pirb_prio_pick #(
    parameter int unsigned N = 15,
    parameter int unsigned W = 4
) (
    input  wire logic [N-1:0] pending,
    input  wire logic [N-1:0] en_high,
    input  wire logic [N-1:0] en_low,
    output logic              found,
    output logic [W-1:0]      index
);

    // Higher levels are scanned first; within a level the lowest position wins.
    always_comb
    begin
        found = 1'b0;
        index = '0;
        for (int lvl = 3; lvl >= 1; lvl--)
        begin
            for (int i = 0; i < N; i++)
            begin
                if (!found && pending[i] &&
                    int'(pirb_pkg::pirb_decode_level(en_high[i], en_low[i])) == lvl)
                begin
                    found = 1'b1;
                    index = W'(i);
                end
            end
        end
    end

endmodule

// file: testbench/pirb_cpu_model.sv
`timescale 1ns/1ps
module pirb_cpu_model (
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic       take_en,
    input  wire logic [3:0] wait_cycles,
    input  wire logic       irq_request,
    input  wire logic [3:0] irq_vector,
    output logic            irq_ack,
    output logic [3:0]      taken_vector,
    output int              ack_count
);
    int waited = 0;

    initial
    begin
        irq_ack = 1'b0;
        taken_vector = 4'h0;
        ack_count = 0;
    end

    // The core acknowledges only a standing request, after a chosen delay, for one cycle.
    always @(negedge clk)
    begin
        if (!nrst || irq_ack || !take_en || irq_request !== 1'b1)
        begin
            irq_ack <= 1'b0;
            waited <= 0;
        end
        else if (waited >= int'(wait_cycles))
        begin
            irq_ack <= 1'b1;
            taken_vector <= irq_vector;
            ack_count <= ack_count + 1;
            waited <= 0;
        end
        else
        begin
            waited <= waited + 1;
        end
    end
endmodule

// file: testbench/pirb_tb.sv
`timescale 1ns/1ps
module pirb_tb;
    logic                    clk = 1'b0;
    logic                    nrst = 1'b0;
    pirb_pkg::pirb_reg_req_t reg_req = '0;
    pirb_pkg::pirb_src_t     src = '0;
    logic [7:0]              reg_rdata;
    logic [7:0]              pa_eh = 8'h00;
    logic [7:0]              pa_el = 8'h00;
    logic [3:0]              pc_eh = 4'h0;
    logic [3:0]              pc_el = 4'h0;
    logic                    me_set = 1'b0;
    logic                    me_clr = 1'b0;
    logic                    master;
    logic                    irq_request;
    logic [3:0]              irq_vector;
    logic                    irq_ack;
    logic                    take_en = 1'b0;
    logic [3:0]              wait_cycles = 4'h0;
    logic [3:0]              taken_vector;
    int                      ack_count;
    int                      n_errors = 0;
    int                      comparisons = 0;
    int                      cycles = 0;
    logic [11:0]             addrs [6] = '{12'hFC0, 12'hFC1, 12'hFC2, 12'hFC3, 12'hFC6, 12'hFC4};
    logic [7:0]              masks [6] = '{8'h61, 8'h61, 8'h79, 8'hFF, 8'h0F, 8'h00};
    logic [3:0]              order [5] = '{4'h2, 4'hA, 4'hE, 4'h3, 4'h0};
    logic [14:0]             s;

    always #5 clk = ~clk;

    pirb_top dut (
        .clk(clk), .nrst(nrst), .reg_req(reg_req), .reg_rdata(reg_rdata), .src(src),
        .port_a_enable_high(pa_eh), .port_a_enable_low(pa_el),
        .port_c_enable_high(pc_eh), .port_c_enable_low(pc_el),
        .master_enable_set(me_set), .master_enable_clear(me_clr),
        .master_interrupt_enable(master), .irq_request(irq_request),
        .irq_vector(irq_vector), .irq_ack(irq_ack)
    );

    pirb_cpu_model cpu (
        .clk(clk), .nrst(nrst), .take_en(take_en), .wait_cycles(wait_cycles),
        .irq_request(irq_request), .irq_vector(irq_vector), .irq_ack(irq_ack),
        .taken_vector(taken_vector), .ack_count(ack_count)
    );

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic reg_write(input logic [11:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_req = '{write: 1'b1, read: 1'b0, addr: a, wdata: d};
        @(negedge clk);
        reg_req.write = 1'b0;
    endtask

    task automatic check_reg(input logic [11:0] a, input logic [7:0] exp);
        @(negedge clk);
        reg_req = '{write: 1'b0, read: 1'b1, addr: a, wdata: 8'h00};
        @(negedge clk);
        reg_req.read = 1'b0;
        check($sformatf("register %h", a), exp, reg_rdata);
    endtask

    task automatic pulse_master(input logic set);
        @(negedge clk);
        me_set = set;
        me_clr = !set;
        @(negedge clk);
        me_set = 1'b0;
        me_clr = 1'b0;
    endtask

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            n_errors++;
            $display("unexpected run length expected 5000 seen %0d", cycles);
            test_done();
        end
    end

    initial
    begin
        repeat (10) @(posedge clk);
        @(negedge clk);
        nrst = 1'b1;
        foreach (addrs[i]) check_reg(addrs[i], 8'h00);
        $display("test reset values done");
        foreach (addrs[i])
        begin
            reg_write(addrs[i], 8'hFF);
            check_reg(addrs[i], masks[i]);
            reg_write(addrs[i], 8'h00);
            check_reg(addrs[i], 8'h00);
        end
        $display("test register access done");
        // Each source alone, interrupts globally off, so the flags are only polled.
        for (int k = 0; k < 15; k++)
        begin
            s = 15'(1) << k;
            @(negedge clk);
            src = pirb_pkg::pirb_src_t'(s);
            @(negedge clk);
            src = '0;
            check_reg(12'hFC0, {1'b0, s[14], s[13], 4'h0, s[12]});
            check_reg(12'hFC3, s[11:4]);
            check_reg(12'hFC6, {4'h0, s[3:0]});
            check("irq_request", 8'h00, {7'h00, irq_request});
            reg_write(12'hFC0, 8'h00);
            reg_write(12'hFC3, 8'h00);
            reg_write(12'hFC6, 8'h00);
        end
        $display("test polled sources done");
        reg_write(12'hFC1, 8'h01);
        reg_write(12'hFC2, 8'h41);
        pa_eh = 8'h81;
        pa_el = 8'h01;
        pc_eh = 4'h1;
        pc_el = 4'h1;
        reg_write(12'hFC0, 8'h61);
        reg_write(12'hFC3, 8'h81);
        reg_write(12'hFC6, 8'h01);
        take_en = 1'b1;
        foreach (order[i])
        begin
            wait_cycles = (i % 2 == 1) ? 4'h3 : 4'h0;
            pulse_master(1'b1);
            for (int k = 0; k < 40 && ack_count <= i; k++) @(negedge clk);
            check("served vector", {4'h0, order[i]}, {4'h0, taken_vector});
            @(negedge clk);
            check("master enable", 8'h00, {7'h00, master});
            check("irq_request", 8'h00, {7'h00, irq_request});
        end
        check_reg(12'hFC0, 8'h20);
        check_reg(12'hFC3, 8'h00);
        check_reg(12'hFC6, 8'h00);
        $display("test priority service done");
        take_en = 1'b0;
        reg_write(12'hFC6, 8'h01);
        repeat (3) @(negedge clk);
        check("irq_request", 8'h00, {7'h00, irq_request});
        pulse_master(1'b1);
        repeat (2) @(negedge clk);
        check("irq_request", 8'h01, {7'h00, irq_request});
        check("irq_vector", 8'h0E, {4'h0, irq_vector});
        pulse_master(1'b0);
        repeat (2) @(negedge clk);
        check("irq_request", 8'h00, {7'h00, irq_request});
        reg_write(12'hFC6, 8'h00);
        $display("test master gate done");
        @(negedge clk);
        reg_req = '{write: 1'b1, read: 1'b0, addr: 12'hFC0, wdata: 8'h00};
        src.timer_one = 1'b1;
        @(negedge clk);
        reg_req.write = 1'b0;
        src = '0;
        check_reg(12'hFC0, 8'h40);
        $display("test set wins done");
        test_done();
    end
endmodule
